// ===== design/spfc_cfg.svh
// constants of the serial port frame configuration slice
// assumes byte-wide register port with word-free byte offsets
`ifndef SPFC_CFG_SVH
`define SPFC_CFG_SVH

`define SPFC_OFS_FRAME 4'h7
`define SPFC_OFS_DIV_LO 4'h8
`define SPFC_OFS_DIV_HI 4'h9
`define SPFC_OFS_WINDOW 4'ha
`define SPFC_OFS_DEBUG 4'hb
`define SPFC_OFS_EVENT 4'hc
`define SPFC_OFS_PULSE 4'hd
`define SPFC_RST_FRAME 8'h03
`define SPFC_RST_ZERO 8'h00
`define SPFC_POS_MODE 6
`define SPFC_POS_PARITY 4
`define SPFC_POS_STOP 3
`define SPFC_POS_ORDER 2
`define SPFC_POS_PHASE 1
`define SPFC_PULSE_316 8'h00
`define SPFC_PULSE_PASS 8'hff

`endif

// ===== design/spfc_pkg.sv
// types of the serial port frame configuration slice
// assumes spfc_cfg.svh is compiled alongside
package spfc_pkg;
	// communication mode, in field-code order
	typedef enum logic [1:0] {
		SPFC_ASYNC,
		SPFC_SYNC,
		SPFC_INFRARED,
		SPFC_HOST_SPI
	} spfc_mode_e;
	// decoded frame settings handed to shifter logic
	typedef struct packed {
		spfc_mode_e mode;
		logic parity_en;
		logic parity_odd;
		logic two_stop;
		logic [3:0] data_bits;
		logic nine_bit_low_first;
		logic nine_bit_high_first;
		logic spi_lsb_first;
		logic spi_trailing_sample;
	} spfc_frame_s;
	// infrared pulse shaping selection
	typedef struct packed {
		logic three_sixteenths;
		logic passthrough;
		logic [7:0] fixed_clocks;
	} spfc_pulse_s;
endpackage

// ===== design/spfc_regs.sv
// register slice for frame format, rate divisor and infrared options
// assumes a single-cycle byte register port and synchronous inputs
`timescale 1ns/1ps
`include "spfc_cfg.svh"
module spfc_regs (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic [3:0] addr_i, // byte offset
	input wire logic [7:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	input wire logic debug_halt_i, // processor halted in debug
	input wire logic rx_pin_i, // receive pin level
	input wire logic ir_event_i, // event channel level
	output logic [7:0] rdata_o, // read data, cycle after rd
	output spfc_pkg::spfc_frame_s frame_o, // decoded frame
	output logic [15:0] rate_divisor_o, // divisor value
	output logic prescaler_reload_o, // pulse on divisor write
	output logic [1:0] autorate_window_o, // tolerance code
	output logic periph_run_o, // peripheral may advance
	output logic ir_rx_in_o, // selected infrared input
	output spfc_pkg::spfc_pulse_s pulse_o, // infrared pulse shape
	output logic pulse_active_o // pulse shaping in use
);
	// raw register contents
	logic [7:0] frame_q, frame_d;
	logic [15:0] div_q, div_d;
	logic [7:0] window_q, window_d;
	logic [7:0] debug_q, debug_d;
	logic [7:0] event_q, event_d;
	logic [7:0] pulse_q, pulse_d;
	// registered outputs
	logic [7:0] rdata_q, rdata_d;
	spfc_pkg::spfc_frame_s frame_out_q, frame_out_d;
	logic reload_q, reload_d;
	logic run_q, run_d;
	logic ir_in_q, ir_in_d;
	spfc_pkg::spfc_pulse_s pulse_out_q, pulse_out_d;
	logic pulse_act_q, pulse_act_d;

	// register writes; unmapped offsets are dropped silently
	always_comb begin
		frame_d = frame_q;
		div_d = div_q;
		window_d = window_q;
		debug_d = debug_q;
		event_d = event_q;
		pulse_d = pulse_q;
		reload_d = 1'b0;
		if (wr_i) begin
			unique case (addr_i)
				`SPFC_OFS_FRAME: frame_d = wdata_i;
				`SPFC_OFS_DIV_LO: begin
					div_d[7:0] = wdata_i;
					reload_d = 1'b1;
				end
				`SPFC_OFS_DIV_HI: begin
					div_d[15:8] = wdata_i;
					reload_d = 1'b1;
				end
				`SPFC_OFS_WINDOW: window_d = {wdata_i[7:6], 6'h00};
				`SPFC_OFS_DEBUG: debug_d = {7'h00, wdata_i[0]};
				`SPFC_OFS_EVENT: event_d = {7'h00, wdata_i[0]};
				`SPFC_OFS_PULSE: pulse_d = wdata_i;
				default: ;
			endcase
		end
	end

	// read mux; data valid only the cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				`SPFC_OFS_FRAME: begin
					// spi view shows only mode, order and phase
					if (frame_q[7:6] == 2'h3) begin
						rdata_d = {frame_q[7:6], 3'h0, frame_q[2:1], 1'b0};
					end else begin
						rdata_d = frame_q;
					end
				end
				`SPFC_OFS_DIV_LO: rdata_d = div_q[7:0];
				`SPFC_OFS_DIV_HI: rdata_d = div_q[15:8];
				`SPFC_OFS_WINDOW: rdata_d = window_q;
				`SPFC_OFS_DEBUG: rdata_d = debug_q;
				`SPFC_OFS_EVENT: rdata_d = event_q;
				`SPFC_OFS_PULSE: rdata_d = pulse_q;
				default: rdata_d = 8'h00; // unmapped reads zero
			endcase
		end
	end

	// decode frame settings for the shifters
	always_comb begin
		frame_out_d = '0;
		frame_out_d.mode = spfc_pkg::spfc_mode_e'(frame_q[7:6]);
		if (frame_out_d.mode == spfc_pkg::SPFC_HOST_SPI) begin
			// low bits mean order and phase here, frame fields void
			frame_out_d.spi_lsb_first = frame_q[`SPFC_POS_ORDER];
			frame_out_d.spi_trailing_sample =
				frame_q[`SPFC_POS_PHASE];
			frame_out_d.data_bits = 4'h8;
		end else begin
			// code 1 reserved: treated as disabled, the safe choice
			frame_out_d.parity_en = frame_q[5];
			frame_out_d.parity_odd = frame_q[5] & frame_q[4];
			frame_out_d.two_stop = frame_q[`SPFC_POS_STOP];
			// one width for both directions
			unique case (frame_q[2:0])
				3'h0: frame_out_d.data_bits = 4'h5;
				3'h1: frame_out_d.data_bits = 4'h6;
				3'h2: frame_out_d.data_bits = 4'h7;
				3'h6: begin
					frame_out_d.data_bits = 4'h9;
					frame_out_d.nine_bit_low_first = 1'b1;
				end
				3'h7: begin
					frame_out_d.data_bits = 4'h9;
					frame_out_d.nine_bit_high_first = 1'b1;
				end
				default: frame_out_d.data_bits = 4'h8; // 8 and reserved
			endcase
		end
	end

	// debug halt gate, infrared input select and pulse shape
	always_comb begin
		run_d = debug_q[0] | ~debug_halt_i;
		// event enable cuts the receive pin off entirely
		ir_in_d = event_q[0] ? ir_event_i : rx_pin_i;
		pulse_out_d.three_sixteenths =
			(pulse_q == `SPFC_PULSE_316);
		pulse_out_d.passthrough = (pulse_q == `SPFC_PULSE_PASS);
		pulse_out_d.fixed_clocks = pulse_q;
		// shaping matters only in infrared mode
		pulse_act_d = (frame_q[7:6] == 2'h2);
	end

	// state registers; reset gives async, no parity, 1 stop, 8 bits
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			frame_q <= `SPFC_RST_FRAME;
			div_q <= 16'h0000;
			window_q <= `SPFC_RST_ZERO;
			debug_q <= `SPFC_RST_ZERO;
			event_q <= `SPFC_RST_ZERO;
			pulse_q <= `SPFC_RST_ZERO;
			rdata_q <= 8'h00;
			frame_out_q <= '0;
			reload_q <= 1'b0;
			run_q <= 1'b0;
			ir_in_q <= 1'b0;
			pulse_out_q <= '0;
			pulse_act_q <= 1'b0;
		end else begin
			frame_q <= frame_d;
			div_q <= div_d;
			window_q <= window_d;
			debug_q <= debug_d;
			event_q <= event_d;
			pulse_q <= pulse_d;
			rdata_q <= rdata_d;
			frame_out_q <= frame_out_d;
			reload_q <= reload_d;
			run_q <= run_d;
			ir_in_q <= ir_in_d;
			pulse_out_q <= pulse_out_d;
			pulse_act_q <= pulse_act_d;
		end
	end

	// outputs straight from flip-flops
	assign rdata_o = rdata_q;
	assign frame_o = frame_out_q;
	assign rate_divisor_o = div_q;
	assign prescaler_reload_o = reload_q;
	assign autorate_window_o = window_q[7:6];
	assign periph_run_o = run_q;
	assign ir_rx_in_o = ir_in_q;
	assign pulse_o = pulse_out_q;
	assign pulse_active_o = pulse_act_q;
endmodule

// ===== verification/spfc_remote.sv
// far side model: receive pin and event channel
// assumes one clock; both lines keep moving
`timescale 1ns/1ps
module spfc_remote (
	input wire logic clk_sys_i,
	output logic rx_pin_o,
	output logic ir_event_o
);
	// opposite phases expose a wrong input select
	initial rx_pin_o = 1'b1;
	always @(posedge clk_sys_i) rx_pin_o <= ~rx_pin_o;
	assign ir_event_o = ~rx_pin_o;
endmodule

// ===== verification/spfc_regs_chk.sv
// assertions on the register slice ports
// assumes bind onto spfc_regs, one clock
`timescale 1ns/1ps
module spfc_regs_chk (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic debug_halt_i,
	input wire logic [15:0] rate_divisor_o,
	input wire logic prescaler_reload_o,
	input wire logic periph_run_o,
	input wire spfc_pkg::spfc_frame_s frame_o,
	input wire spfc_pkg::spfc_pulse_s pulse_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	// writes; decoded outputs lag one edge more
	sequence s_div; wr_i && addr_i[3:1] == 3'h4; endsequence
	sequence s_frm; wr_i && addr_i == 4'h7; endsequence
	AST_RELOAD: assert property (s_div |=> prescaler_reload_o)
		else $error("no reload");
	AST_DIV_LO: assert property (s_div ##0 !addr_i[0] |=>
		rate_divisor_o[7:0] == $past(wdata_i)) else $error("bad low");
	AST_DIV_HI: assert property (s_div ##0 addr_i[0] |=>
		rate_divisor_o[15:8] == $past(wdata_i)) else $error("bad high");
	AST_MODE: assert property (s_frm |=> ##1
		frame_o.mode == $past(wdata_i[7:6], 2)) else $error("bad mode");
	AST_PARITY: assert property (s_frm ##0 wdata_i[7:6] != 2'h3 |=> ##1
		frame_o.parity_en == $past(wdata_i[5], 2)) else $error("bad par");
	AST_SPI: assert property (s_frm ##0 wdata_i[7:6] == 2'h3 |=> ##1
		frame_o.spi_lsb_first == $past(wdata_i[2], 2)) else $error("bad ord");
	AST_RUN: assert property (!debug_halt_i |=> periph_run_o)
		else $error("halted");
	AST_PULSE: assert property (wr_i && addr_i == 4'hd && wdata_i == 8'hff
		|=> ##1 pulse_o.passthrough) else $error("no pass");
endmodule
bind spfc_regs spfc_regs_chk chk (.clk_sys_i, .arst_n_i, .addr_i, .wdata_i,
	.wr_i, .debug_halt_i, .rate_divisor_o, .prescaler_reload_o,
	.periph_run_o, .frame_o, .pulse_o);

// ===== verification/serial_port_frame_config_tb.sv
// self-checking bench for the frame configuration slice
// assumes spfc_regs, spfc_remote and the checker compiled first
`timescale 1ns/1ps
module serial_port_frame_config_tb;
	logic clk_sys_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic debug_halt_i = 1'b0, rx, ev, rl, run, ir, act;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o;
	logic [15:0] dv;
	logic [1:0] wn;
	spfc_pkg::spfc_frame_s fr;
	spfc_pkg::spfc_pulse_s pl;
	int miscompares = 0, check_count = 0, cyc = 0;
	spfc_remote far (.clk_sys_i, .rx_pin_o(rx), .ir_event_o(ev));
	spfc_regs uut (.clk_sys_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.debug_halt_i, .rx_pin_i(rx), .ir_event_i(ev), .rdata_o,
		.frame_o(fr), .rate_divisor_o(dv), .prescaler_reload_o(rl),
		.autorate_window_o(wn), .periph_run_o(run), .ir_rx_in_o(ir),
		.pulse_o(pl), .pulse_active_o(act));
	initial forever #25 clk_sys_i = ~clk_sys_i;
	task chk(string n, logic [15:0] e, logic [15:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	// one-cycle strobes, released on the next edge
	task wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	// write, then let the decoded outputs land
	task wrs(logic [3:0] a, logic [7:0] d);
		wr(a, d);
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask
	task rd(logic [3:0] a, logic [7:0] e);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("rdata", e, rdata_o);
	endtask
	task t_reset;
		rd(4'h7, 8'h03);
		for (int a = 8; a < 15; a++) rd(a[3:0], 8'h00);
		chk("run", 1, run);
		chk("pin", !rx, ir);
		chk("rbits", 8, fr.data_bits);
		chk("rpar", 0, fr.parity_en);
		$display("reset done");
	endtask
	task t_frame;
		for (int m = 0; m < 4; m++) begin
			wrs(4'h7, {m[1:0], 6'h3e});
			chk("mode", m, fr.mode);
			chk("ir", m == 2, act);
			rd(4'h7, m == 3 ? 8'hc6 : {m[1:0], 6'h3e});
		end
		chk("trail", 1, fr.spi_trailing_sample);
		// reserved parity code 1 skipped; width code 0 checked as 5 bits
		for (int p = 0; p < 4; p += (p == 0) ? 2 : 1) begin
			wrs(4'h7, {2'h0, p[1:0], 4'h0});
			chk("par", p > 1, fr.parity_en);
			chk("odd", p == 3, fr.parity_odd);
			chk("bits", 5, fr.data_bits);
		end
		wrs(4'h7, 8'h0f);
		chk("stop", 1, fr.two_stop);
		chk("nine", 9, fr.data_bits);
		chk("hi", 1, fr.nine_bit_high_first);
		$display("frame done");
	endtask
	task t_div;
		wr(4'h8, 8'h5a);
		@(negedge clk_sys_i);
		chk("rl", 1, rl);
		wr(4'h9, 8'ha5);
		@(negedge clk_sys_i);
		chk("div", 16'ha55a, dv);
		rd(4'h9, 8'ha5);
		chk("rl0", 0, rl);
		$display("div done");
	endtask
	task t_misc;
		wr(4'ha, 8'hff);
		rd(4'ha, 8'hc0);
		chk("win", 3, wn);
		@(posedge clk_sys_i);
		debug_halt_i <= 1'b1;
		wrs(4'hb, 8'h00);
		chk("halt", 0, run);
		wrs(4'hb, 8'h01);
		chk("run", 1, run);
		wrs(4'hc, 8'h01);
		chk("ev", rx, ir);
		wrs(4'hd, 8'h07);
		chk("fix", 7, pl.fixed_clocks);
		wrs(4'hd, 8'hff);
		chk("pass", 1, pl.passthrough);
		$display("misc done");
	endtask
	task stop_test;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_frame();
		t_div();
		t_misc();
		stop_test();
	end
	// hang guard, far above the fewer than a hundred cycles used
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			stop_test();
		end
	end
endmodule
